// ===== design/dric_pkg.sv
// package for the receive line input conditioner
// assumes a 32-bit classic wishbone bus and an 8-bit config register
package dric_pkg;

	// bus and register geometry
	localparam int DATA_W = 32;
	localparam int CFG_W  = 8;
	localparam int PAD_W  = DATA_W - CFG_W;

	// register index; byte address is four times it
	localparam int REG_IDX  = 3;
	localparam int REG_ADDR = REG_IDX * 4;

	// field positions in the config register
	localparam int BIT_SDO = 6;
	localparam int BIT_DIG = 5;
	localparam int BIT_NIV = 4;
	localparam int BIT_PIV = 3;
	localparam int BIT_UNI = 2;
	localparam int BIT_FAL = 1;
	localparam int BIT_RZP = 0;

	// reset value and writable bits
	localparam logic [CFG_W-1:0] CFG_RESET   = 8'h00;
	localparam logic [CFG_W-1:0] CFG_WR_MASK = 8'h7f;

	// read padding and unmapped answer
	localparam logic [PAD_W-1:0]  PAD_ZERO  = 24'h000000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

	// rail indices
	localparam int RAIL_POS = 0;
	localparam int RAIL_NEG = 1;
	localparam int RAILS    = 2;

endpackage : dric_pkg

// ===== design/dric_top.sv
// receive line input conditioner: wishbone config, pin muxing, rz forming
// assumes core_clk at 100 MHz, a free or gated link clock on rxLineClockIn,
// and a clock and data recovery block that oversamples the outputs
`timescale 1ns/10ps

module dric_top #(
	parameter int ADDR_W = 8
) (
	// core clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	// wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [ADDR_W-1:0]           wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [dric_pkg::DATA_W-1:0] wb_dat_i,
	output logic      [dric_pkg::DATA_W-1:0] wb_dat_o,
	output logic                             wb_ack_o,
	// link clock
	input  wire logic                        rxLineClockIn,
	// shared positive pin
	input  wire logic                        rxPosIn,
	output logic                             slicedPosOut,
	output logic                             slicedPosOe,
	// shared negative pin
	input  wire logic                        rxNegIn,
	output logic                             slicedNegOut,
	output logic                             slicedNegOe,
	// analog slicer
	input  wire logic                        slicerPos,
	input  wire logic                        slicerNeg,
	input  wire logic                        slicerPowered,
	// clock and data recovery feed
	output logic                             cdrPos,
	output logic                             cdrNeg,
	output logic                             cdrUnipolar
);
	import dric_pkg::*;

	localparam logic [ADDR_W-3:0] REG_HIT_IDX = (ADDR_W-2)'(REG_IDX);

	// link side copy of the config: rail inverts low, edge select on top
	localparam int LINK_CFG_W = RAILS + 1;
	localparam int LINK_FAL   = RAILS;

	// rail conditioning shared by both sampling edges
	function automatic logic railCond(input logic level, input logic invert);
		railCond = level ^ invert;
	endfunction : railCond

	// core domain state
	logic [CFG_W-1:0]  cfg_reg;
	logic [CFG_W-1:0]  cfg_next;
	logic              ack_reg;
	logic [DATA_W-1:0] datOut_reg;
	logic [DATA_W-1:0] datOut_next;

	// core side synchronisers
	logic [RAILS-1:0] rzMeta_reg;
	logic [RAILS-1:0] rzSync_reg;
	logic [RAILS-1:0] pinMeta_reg;
	logic [RAILS-1:0] pinSync_reg;
	logic [2:0]       slcMeta_reg;
	logic [2:0]       slcSync_reg;

	// core outputs
	logic [RAILS-1:0] cdr_reg;
	logic [RAILS-1:0] cdr_next;
	logic             uni_reg;
	logic [RAILS-1:0] pinOut_reg;
	logic [RAILS-1:0] pinOut_next;
	logic [RAILS-1:0] pinOe_reg;

	// link domain state
	logic                  rstMeta_reg;
	logic                  linkRst_reg;
	logic [LINK_CFG_W-1:0] cfgLink_reg;
	logic [RAILS-1:0]      rzLink;

	// config hand-over between the domains
	logic [LINK_CFG_W-1:0] xferHold_reg;
	logic                  xferReq_reg;
	logic                  ackMeta_reg;
	logic                  ackSync_reg;
	logic                  reqMeta_reg;
	logic                  reqSync_reg;
	logic                  linkAck_reg;
	wire  [LINK_CFG_W-1:0] linkCfgWant;
	wire                   xferIdle;
	wire                   xferStart;
	wire                   xferLand;

	// bus decode
	wire              busReq;
	wire              regHit;
	wire              wrEn;
	wire              rdNew;
	wire [DATA_W-1:0] readWord;

	// mode decode
	wire              slcOutOn;
	wire              digPath;
	wire              passOn;
	wire [RAILS-1:0]  invBits;
	wire [RAILS-1:0]  pinRaw;
	wire [RAILS-1:0]  slcRails;
	wire [RAILS-1:0]  digRails;

	// request decode on the wishbone side
	assign busReq = wb_cyc_i & wb_stb_i;
	assign regHit = (wb_adr_i[ADDR_W-1:2] == REG_HIT_IDX);
	assign rdNew  = busReq & ~ack_reg;
	assign wrEn   = rdNew & wb_we_i & regHit & wb_sel_i[0];

	// top bit never takes a write and reads zero
	assign cfg_next = wrEn
		? ((wb_dat_i[CFG_W-1:0] & CFG_WR_MASK) | (cfg_reg & ~CFG_WR_MASK))
		: cfg_reg;

	// unmapped addresses read zero
	assign readWord    = regHit ? {PAD_ZERO, cfg_reg} : DATA_ZERO;
	assign datOut_next = rdNew ? readWord : datOut_reg;

	// config register
	always_ff @(posedge core_clk)
	begin
		if (rst)
			cfg_reg <= CFG_RESET;
		else
			cfg_reg <= cfg_next;
	end

	// one acknowledge per taken request
	always_ff @(posedge core_clk)
	begin
		if (rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= rdNew;
	end

	// read data, held until the next request
	always_ff @(posedge core_clk)
	begin
		if (rst)
			datOut_reg <= DATA_ZERO;
		else
			datOut_reg <= datOut_next;
	end

	// mode bits
	assign slcOutOn = cfg_reg[BIT_SDO];
	assign digPath  = cfg_reg[BIT_DIG] & ~slcOutOn;
	assign passOn   = cfg_reg[BIT_RZP] & ~cfg_reg[BIT_UNI];
	assign invBits  = {cfg_reg[BIT_NIV], cfg_reg[BIT_PIV]};

	// pin and slicer vectors
	assign pinRaw   = {rxNegIn, rxPosIn};
	assign slcRails = slcSync_reg[1:0];

	// pass-through uses synced pins, no link clock
	assign digRails = passOn
		? (pinSync_reg ^ invBits)
		: rzSync_reg;

	// recovery feed selection
	assign cdr_next = digPath ? digRails : slcRails;

	// slicer pulses on the pins only when powered
	assign pinOut_next = slcRails & {RAILS{slcSync_reg[2]}};

	// two-flop synchroniser for the rz pulses from the link side
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rzMeta_reg <= '0;
			rzSync_reg <= '0;
		end
		else
		begin
			rzMeta_reg <= rzLink;
			rzSync_reg <= rzMeta_reg;
		end
	end

	// two-flop synchroniser for the pins, used by pass-through
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end
		else
		begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
		end
	end

	// two-flop synchroniser for the slicer rails and power flag
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			slcMeta_reg <= '0;
			slcSync_reg <= '0;
		end
		else
		begin
			slcMeta_reg <= {slicerPowered, slicerNeg, slicerPos};
			slcSync_reg <= slcMeta_reg;
		end
	end

	// registered outputs toward recovery and the shared pins
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cdr_reg    <= '0;
			uni_reg    <= 1'b0;
			pinOut_reg <= '0;
			pinOe_reg  <= '0;
		end
		else
		begin
			cdr_reg    <= cdr_next;
			uni_reg    <= cfg_reg[BIT_UNI] & digPath;
			pinOut_reg <= pinOut_next;
			pinOe_reg  <= {RAILS{slcOutOn}};
		end
	end

	// reset brought into the link domain
	always_ff @(posedge rxLineClockIn)
	begin
		rstMeta_reg <= rst;
		linkRst_reg <= rstMeta_reg;
	end

	// hand-over decode: a new word goes out only when the last one is answered
	assign linkCfgWant = {cfg_reg[BIT_FAL], cfg_reg[BIT_NIV], cfg_reg[BIT_PIV]};
	assign xferIdle    = (xferReq_reg == ackSync_reg);
	assign xferStart   = xferIdle & (linkCfgWant != xferHold_reg);
	assign xferLand    = (reqSync_reg != linkAck_reg);

	// core side: hold the word steady and toggle the request
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			xferHold_reg <= '0;
			xferReq_reg  <= 1'b0;
		end
		else if (xferStart)
		begin
			xferHold_reg <= linkCfgWant;
			xferReq_reg  <= ~xferReq_reg;
		end
	end

	// core side: answer back through two flops
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ackMeta_reg <= 1'b0;
			ackSync_reg <= 1'b0;
		end
		else
		begin
			ackMeta_reg <= linkAck_reg;
			ackSync_reg <= ackMeta_reg;
		end
	end

	// link side: request through two flops
	always_ff @(posedge rxLineClockIn)
	begin
		if (linkRst_reg)
		begin
			reqMeta_reg <= 1'b0;
			reqSync_reg <= 1'b0;
		end
		else
		begin
			reqMeta_reg <= xferReq_reg;
			reqSync_reg <= reqMeta_reg;
		end
	end

	// link side: take the held word once per request, then answer
	always_ff @(posedge rxLineClockIn)
	begin
		if (linkRst_reg)
		begin
			cfgLink_reg <= '0;
			linkAck_reg <= 1'b0;
		end
		else if (xferLand)
		begin
			cfgLink_reg <= xferHold_reg;
			linkAck_reg <= reqSync_reg;
		end
	end

	// per rail sampling and rz forming on both link edges
	genvar gi;
	generate
		for (gi = 0; gi < RAILS; gi++)
		begin : g_rail
			logic sampR_reg;
			logic togR_reg;
			logic copyR_reg;
			logic sampF_reg;
			logic togF_reg;
			logic copyF_reg;
			wire  invLink;
			wire  rzRise;
			wire  rzFall;

			// rail invert after the sampling flop
			assign invLink = cfgLink_reg[gi];

			// rising edge: sample, toggle on a one, copy falling toggle
			always_ff @(posedge rxLineClockIn)
			begin
				if (linkRst_reg)
				begin
					sampR_reg <= 1'b0;
					togR_reg  <= 1'b0;
					copyF_reg <= 1'b0;
				end
				else
				begin
					sampR_reg <= pinRaw[gi];
					togR_reg  <= togR_reg ^ railCond(sampR_reg, invLink);
					copyF_reg <= togF_reg;
				end
			end

			// falling edge: sample, toggle on a one, copy rising toggle
			always_ff @(negedge rxLineClockIn)
			begin
				if (linkRst_reg)
				begin
					sampF_reg <= 1'b0;
					togF_reg  <= 1'b0;
					copyR_reg <= 1'b0;
				end
				else
				begin
					sampF_reg <= pinRaw[gi];
					togF_reg  <= togF_reg ^ railCond(sampF_reg, invLink);
					copyR_reg <= togR_reg;
				end
			end

			// half period pulse between toggle and its copy
			assign rzRise = togR_reg ^ copyR_reg;
			assign rzFall = togF_reg ^ copyF_reg;

			// edge select
			assign rzLink[gi] = cfgLink_reg[LINK_FAL] ? rzFall : rzRise;
		end
	endgenerate

	// output ports
	assign wb_dat_o     = datOut_reg;
	assign wb_ack_o     = ack_reg;
	assign slicedPosOut = pinOut_reg[RAIL_POS];
	assign slicedNegOut = pinOut_reg[RAIL_NEG];
	assign slicedPosOe  = pinOe_reg[RAIL_POS];
	assign slicedNegOe  = pinOe_reg[RAIL_NEG];
	assign cdrPos       = cdr_reg[RAIL_POS];
	assign cdrNeg       = cdr_reg[RAIL_NEG];
	assign cdrUnipolar  = uni_reg;

endmodule : dric_top

// ===== verif/dric_line_model.sv
// line side partner: link clock, digital pins and analog slicer
// the link clock runs free, as a recovered line clock would
`timescale 1ns/10ps
module dric_line_model (
	// levels from the bench
	input  wire logic posBit,
	input  wire logic negBit,
	input  wire logic powerOn,
	// line side
	output logic      rxLineClockIn,
	output logic      rxPosIn,
	output logic      rxNegIn,
	output logic      slicerPos,
	output logic      slicerNeg,
	output logic      slicerPowered
);
	logic phase;
	// 32 ns link clock, offset from the core clock
	initial
	begin
		{rxLineClockIn, rxPosIn, rxNegIn, slicerPos, slicerNeg, phase} = 6'h00;
		#3;
		forever #16 rxLineClockIn = ~rxLineClockIn;
	end
	// slicer keeps pulsing even when unpowered
	always @(posedge rxLineClockIn)
	begin
		phase <= ~phase;
		slicerPos <= ~phase;
		slicerNeg <= phase;
	end
	// pins change away from the rising sample
	always @(negedge rxLineClockIn)
	begin
		rxPosIn <= posBit;
		rxNegIn <= negBit;
	end
	assign slicerPowered = powerOn;
endmodule : dric_line_model

// ===== verif/dric_monitor.sv
// port checker for the receive conditioner
// bound to dric_top; shadows the config from bus writes
`timescale 1ns/10ps
module dric_monitor #(parameter int ADDR_W = 8) (
	// core
	input wire logic                        core_clk,
	input wire logic                        rst,
	// bus
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [ADDR_W-1:0]           wb_adr_i,
	input wire logic [3:0]                  wb_sel_i,
	input wire logic [dric_pkg::DATA_W-1:0] wb_dat_i,
	input wire logic [dric_pkg::DATA_W-1:0] wb_dat_o,
	input wire logic                        wb_ack_o,
	// line and outputs
	input wire logic                        rxPosIn,
	input wire logic                        slicerPos,
	input wire logic                        slicerPowered,
	input wire logic                        slicedPosOut,
	input wire logic                        slicedPosOe,
	input wire logic                        cdrPos,
	input wire logic                        cdrUnipolar
);
	import dric_pkg::*;
	logic [6:0] cfgReg;
	logic [3:0] calmReg;
	wire        hit   = wb_adr_i == ADDR_W'(REG_ADDR);
	wire        wrHit = wb_ack_o && wb_we_i && hit && wb_sel_i[0];
	wire        calm  = calmReg == 4'hf;
	wire        dig   = cfgReg[BIT_DIG] && !cfgReg[BIT_SDO];
	wire        pass  = dig && cfgReg[BIT_RZP] && !cfgReg[BIT_UNI];
	// shadow config and cycles since it was last written
	always_ff @(posedge core_clk)
	begin
		if (rst || wrHit)
			calmReg <= 4'h0;
		else if (!calm)
			calmReg <= calmReg + 4'h1;
		if (rst)
			cfgReg <= 7'h00;
		else if (wrHit)
			cfgReg <= wb_dat_i[6:0];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	rst_quiet_a: assert property ($fell(rst) |-> !wb_ack_o && !slicedPosOe && !cdrPos)
		else $error("outputs active after reset");
	rd_data_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o == (hit ? {PAD_ZERO, 1'b0, cfgReg} : DATA_ZERO))
		else $error("read data wrong");
	oe_cfg_a: assert property (calm |-> slicedPosOe == cfgReg[BIT_SDO] && cdrUnipolar == (dig && cfgReg[BIT_UNI]))
		else $error("enable or mode flag wrong");
	pin_drive_a: assert property (calm |-> slicedPosOut == $past(slicerPos && slicerPowered, 3))
		else $error("pin drive wrong");
	analog_a: assert property (calm && !dig |-> cdrPos == $past(slicerPos, 3))
		else $error("analog feed wrong");
	pass_a: assert property (calm && pass |-> cdrPos == $past(rxPosIn ^ cfgReg[BIT_PIV], 3))
		else $error("pass through wrong");
	rz_width_a: assert property (calm && dig && !pass && cdrPos && $past(cdrPos) |=> !cdrPos)
		else $error("rz pulse too long");
	cover property (wrHit);
	cover property (calm && pass);
	cover property (calm && dig && !pass && $rose(cdrPos));
endmodule : dric_monitor
bind dric_top dric_monitor #(.ADDR_W(ADDR_W)) mon (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxPosIn, .slicerPos, .slicerPowered,
	.slicedPosOut, .slicedPosOe, .cdrPos, .cdrUnipolar);

// ===== verif/testbench.sv
// self-checking bench for the receive line input conditioner
// bus cycles from tasks, line side from dric_line_model
`timescale 1ns/10ps
module testbench;
	import dric_pkg::*;
	localparam logic [7:0] RA = 8'(REG_ADDR);
	logic              core_clk = 1'b0;
	logic              rst = 1'b1;
	logic              wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [7:0]        wbAdr = 8'h00;
	logic [3:0]        wbSel = 4'h0;
	logic [DATA_W-1:0] wbDatI = 32'h0, wbDatO;
	logic              wbAck, lclk, pIn, nIn, sPos, sNeg, sPow, pOut, pOe, nOut, nOe, cPos, cNeg, cUni;
	logic              posBit = 1'b0, negBit = 1'b0, powerOn = 1'b0;
	int                error_cnt = 0, n_tests = 0, ticks = 0;
	always #5 core_clk = ~core_clk;
	dric_top dut (.core_clk, .rst, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .rxLineClockIn(lclk),
		.rxPosIn(pIn), .slicedPosOut(pOut), .slicedPosOe(pOe), .rxNegIn(nIn), .slicedNegOut(nOut),
		.slicedNegOe(nOe), .slicerPos(sPos), .slicerNeg(sNeg), .slicerPowered(sPow), .cdrPos(cPos),
		.cdrNeg(cNeg), .cdrUnipolar(cUni));
	dric_line_model line (.posBit, .negBit, .powerOn, .rxLineClockIn(lclk), .rxPosIn(pIn),
		.rxNegIn(nIn), .slicerPos(sPos), .slicerNeg(sNeg), .slicerPowered(sPow));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat,
		output logic [31:0] rd);
		@(posedge core_clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, adr, sel, dat};
		do @(posedge core_clk); while (wbAck !== 1'b1);
		rd = wbDatO;
		{wbCyc, wbStb} <= 2'b00;
	endtask : bus
	task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, adr, 4'hf, 32'h0, d);
		chk(d, exp);
	endtask : rdc
	// write config, wait 30 cycles, then count high cycles over 64
	task automatic run(input logic [7:0] cfg, output int p, output int n, output int o);
		logic [31:0] d;
		bus(1'b1, RA, 4'h1, {24'h0, cfg}, d);
		repeat (30) @(posedge core_clk);
		{p, n, o} = '0;
		repeat (64)
		begin
			@(posedge core_clk);
			p += (cPos === 1'b1);
			n += (cNeg === 1'b1);
			o += (pOut === 1'b1);
		end
	endtask : run
	task automatic t_regs;
		logic [31:0] d;
		rdc(RA, 32'h0);
		bus(1'b1, RA, 4'h1, 32'hfe, d);
		rdc(RA, 32'h7e);
		bus(1'b1, RA, 4'h0, 32'h00, d);
		rdc(RA, 32'h7e);
		rdc(8'h10, 32'h0);
	endtask : t_regs
	task automatic t_slicer;
		int p, n, o;
		run(8'h60, p, n, o);
		chk({pOe, nOe}, 32'h3);
		chk(o, 0);
		chk(nOut, 0);
		powerOn <= 1'b1;
		run(8'h60, p, n, o);
		chk(o > 20 && p > 20, 1);
		chk(pOut ^ nOut, 1);
		run(8'h00, p, n, o);
		chk({pOe, p > 20}, 32'h1);
	endtask : t_slicer
	task automatic t_pass;
		int p, n, o;
		posBit <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			run(8'h21 | 8'(i << 3), p, n, o);
			chk(p, i[0] ? 0 : 64);
			chk(n, i[1] ? 64 : 0);
		end
	endtask : t_pass
	task automatic t_rz;
		int p, n, o;
		for (int i = 0; i < 3; i++)
		begin
			run(8'h20 | 8'(i << 1), p, n, o);
			chk(p >= 18 && p <= 42, 1);
			chk(n, 0);
			chk(cUni, i == 2);
		end
		posBit <= 1'b0;
		run(8'h20, p, n, o);
		chk(p, 0);
	endtask : t_rz
	task automatic summarize;
		$display("errors=%0d checks=%0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	// cut a hang short
	always @(posedge core_clk)
	begin
		ticks++;
		if (ticks == 5000)
		begin
			error_cnt++;
			summarize();
		end
	end
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_slicer();
		t_pass();
		t_rz();
		summarize();
	end
endmodule : testbench
